/* logic/scde_engine.sv */
// Purpose: Cover datagram serial master with AXI4-Lite registers
// Assumes: Serial reply input from another domain, synchronised twice
// Notes: Current datagrams arrive on a same-clock request port
// What this block does
// - Two 32-bit cover words hold 64 bits
// - Cover length from config bits 19:13
// - Length above 64 sends 64 bits
// - Zero length uses selected driver format length
// - Format code picks 12, 20, 40 or off
// - Cover LSB sits at low word bit 0
// - Every datagram shifts out MSB first
// - Short datagram: low word write sends it
// - Long datagram: high first, low write sends
// - Reply stored in 64-bit reply pair
// - Done flag set when a cover reply is stored
// - Automatic cover only up to 32 bits
// - Threshold register and automatic enable bit
// - Crossing sends low or high word
// - Replies to all datagrams go to reply pair
// - Driver status bits copied to status 31:24
// - Masked driver status ORed into event 30
// - Zero timing values mean two cycles
// - Clock and select high during block time
// - Reply sampled during the same transfer
module scde_engine (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [8:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [8:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] ramp_velocity_now_in,
	input wire logic cur_req_in,
	input wire logic [63:0] cur_data_in,
	output logic cur_ack_out,
	output logic driver_serial_clock_out,
	output logic driver_select_n_out,
	output logic driver_serial_out_out,
	input wire logic driver_serial_in_in
);
	logic [31:0] homing_r, sout_cfg_r, step_cfg_r, sw_vel_r;
	logic [31:0] pt_low_r, pt_high_r, rp_low_r, rp_high_r;
	logic [31:0] events_r;
	logic [7:0] drv_status_r;
	logic [8:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_have_r, w_have_r;
	logic wr_go;
	logic wr_ok;
	logic [6:0] wr_idx;
	logic rd_go;
	logic rd_clr_events;
	logic cover_pend_r;
	logic auto_pend_r;
	logic auto_sel_high_r;
	logic above_r;
	logic above_now;
	scde_pkg::scde_state_t state_r;
	scde_pkg::scde_frame_t tx_r;
	logic [63:0] rx_r;
	logic [6:0] bit_cnt_r;
	logic [3:0] tim_r;
	logic is_cover_r;
	logic sdi_s1_r, sdi_s2_r;
	logic [6:0] cover_len;
	logic start_cover, start_auto, start_cur;
	logic xfer_end;
	logic [3:0] fmt;
	logic link_on;

	// Pass-through of a narrow time field; zero becomes two cycles
	function automatic logic [3:0] eff_time(input logic [3:0] t);
		eff_time = (t == 4'h0) ? scde_pkg::TIME_MIN : t;
	endfunction : eff_time

	function automatic logic [31:0] abs32(input logic [31:0] v);
		abs32 = v[31] ? (~v + 32'h0000_0001) : v;
	endfunction : abs32

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
	endfunction : merge

	assign fmt = sout_cfg_r[scde_pkg::FMT_LSB +: 4];
	// A zero length would wrap the bit counter, so it never starts a frame
	assign link_on = fmt != 4'h0 && cover_len != 7'h00;

	// Cover length: programmed, clamped, or derived from format
	always_comb
	begin
		cover_len = sout_cfg_r[scde_pkg::LEN_LSB +: 7];
		if (cover_len > scde_pkg::LEN_MAX)
			cover_len = scde_pkg::LEN_MAX;
		if (cover_len == 7'h00)
		begin
			unique case (fmt[3:1])
				3'b100: cover_len = scde_pkg::LEN_FMT_A;
				3'b101: cover_len = scde_pkg::LEN_FMT_B;
				3'b110: cover_len = scde_pkg::LEN_FMT_C;
				default: cover_len = 7'h00;
			endcase
		end
	end

	// AXI write channel capture, either order
	assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
	assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
	assign wr_idx = awaddr_r[8:2];
	always_comb
	begin
		unique case (wr_idx)
			scde_pkg::IDX_HOMING, scde_pkg::IDX_SOUT_CFG,
			scde_pkg::IDX_STEP_CFG, scde_pkg::IDX_SW_VEL,
			scde_pkg::IDX_PT_LOW, scde_pkg::IDX_PT_HIGH: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 9'h000;
			wdata_r <= scde_pkg::RESET_WORD;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= scde_pkg::RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? scde_pkg::RESP_OKAY :
					scde_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Software registers
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			homing_r <= scde_pkg::RESET_WORD;
			sout_cfg_r <= scde_pkg::RESET_WORD;
			step_cfg_r <= scde_pkg::RESET_WORD;
			sw_vel_r <= scde_pkg::RESET_WORD;
			pt_low_r <= scde_pkg::RESET_WORD;
			pt_high_r <= scde_pkg::RESET_WORD;
		end
		else if (ce_in && wr_go)
		begin
			unique case (wr_idx)
				scde_pkg::IDX_HOMING:
					homing_r <= merge(homing_r, wdata_r, wstrb_r);
				scde_pkg::IDX_SOUT_CFG:
					sout_cfg_r <= merge(sout_cfg_r, wdata_r, wstrb_r);
				scde_pkg::IDX_STEP_CFG:
					step_cfg_r <= merge(step_cfg_r, wdata_r, wstrb_r);
				scde_pkg::IDX_SW_VEL:
					sw_vel_r <= merge(sw_vel_r, wdata_r, wstrb_r);
				scde_pkg::IDX_PT_LOW:
					pt_low_r <= merge(pt_low_r, wdata_r, wstrb_r);
				scde_pkg::IDX_PT_HIGH:
					pt_high_r <= merge(pt_high_r, wdata_r, wstrb_r);
				default: ;
			endcase
		end
	end

	// AXI read channel; reading events clears them
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_go = s_axi_arvalid & s_axi_arready;
	assign rd_clr_events = rd_go && (s_axi_araddr[8:2] == scde_pkg::IDX_EVENTS);
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= scde_pkg::RESET_WORD;
			s_axi_rresp <= scde_pkg::RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= scde_pkg::RESP_OKAY;
				unique case (s_axi_araddr[8:2])
					scde_pkg::IDX_HOMING: s_axi_rdata <= homing_r;
					scde_pkg::IDX_SOUT_CFG: s_axi_rdata <= sout_cfg_r;
					scde_pkg::IDX_STEP_CFG: s_axi_rdata <= step_cfg_r;
					scde_pkg::IDX_EVENTS: s_axi_rdata <= events_r;
					scde_pkg::IDX_STATUS:
						s_axi_rdata <= {drv_status_r, 24'h000000};
					scde_pkg::IDX_SW_VEL: s_axi_rdata <= sw_vel_r;
					scde_pkg::IDX_PT_LOW: s_axi_rdata <= pt_low_r;
					scde_pkg::IDX_PT_HIGH: s_axi_rdata <= pt_high_r;
					scde_pkg::IDX_RP_LOW: s_axi_rdata <= rp_low_r;
					scde_pkg::IDX_RP_HIGH: s_axi_rdata <= rp_high_r;
					default:
					begin
						s_axi_rdata <= scde_pkg::RESET_WORD;
						s_axi_rresp <= scde_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Velocity threshold crossing detection
	assign above_now = abs32(ramp_velocity_now_in) >= sw_vel_r;
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			above_r <= 1'b0;
		else if (ce_in)
			above_r <= above_now;
	end

	// Pending requests; a new request wins over its own clear
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cover_pend_r <= 1'b0;
			auto_pend_r <= 1'b0;
			auto_sel_high_r <= 1'b0;
		end
		else if (ce_in)
		begin
			if (start_cover)
				cover_pend_r <= 1'b0;
			if (wr_go && wr_idx == scde_pkg::IDX_PT_LOW && link_on)
				cover_pend_r <= 1'b1;
			if (start_auto)
				auto_pend_r <= 1'b0;
			if (homing_r[scde_pkg::AUTO_COVER_BIT] && above_now != above_r
				&& cover_len <= scde_pkg::LEN_WORD && link_on)
			begin
				auto_pend_r <= 1'b1;
				auto_sel_high_r <= above_now;
			end
		end
	end

	assign start_cover = state_r == scde_pkg::ST_IDLE && cover_pend_r;
	assign start_auto = state_r == scde_pkg::ST_IDLE && !cover_pend_r
		&& auto_pend_r;
	assign start_cur = state_r == scde_pkg::ST_IDLE && !cover_pend_r
		&& !auto_pend_r && cur_req_in && link_on;
	assign cur_ack_out = start_cur;
	assign xfer_end = state_r == scde_pkg::ST_HIGH && tim_r == 4'h1
		&& bit_cnt_r == 7'h01;

	// Reply input synchroniser
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sdi_s1_r <= 1'b0;
			sdi_s2_r <= 1'b0;
		end
		else if (ce_in)
		begin
			sdi_s1_r <= driver_serial_in_in;
			sdi_s2_r <= sdi_s1_r;
		end
	end

	// Serial engine: low phase, high phase per bit, then block time
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_r <= scde_pkg::ST_BLOCK;
			tx_r <= '0;
			rx_r <= 64'h0;
			bit_cnt_r <= 7'h00;
			tim_r <= scde_pkg::TIME_MIN;
			is_cover_r <= 1'b0;
		end
		else if (ce_in)
		begin
			unique case (state_r)
				scde_pkg::ST_IDLE:
				begin
					if (start_cover || start_auto || start_cur)
					begin
						state_r <= scde_pkg::ST_LOW;
						tim_r <= eff_time(sout_cfg_r[scde_pkg::LOWT_LSB +: 4]);
						rx_r <= 64'h0;
						is_cover_r <= start_cover | start_auto;
						if (start_cover)
						begin
							tx_r.data <= {pt_high_r, pt_low_r};
							tx_r.len <= cover_len;
							bit_cnt_r <= cover_len;
						end
						else if (start_auto)
						begin
							tx_r.data <= {32'h0, auto_sel_high_r ?
								pt_high_r : pt_low_r};
							tx_r.len <= cover_len;
							bit_cnt_r <= cover_len;
						end
						else
						begin
							tx_r.data <= cur_data_in;
							tx_r.len <= cover_len;
							bit_cnt_r <= cover_len;
						end
					end
				end
				scde_pkg::ST_LOW:
				begin
					if (tim_r == 4'h1)
					begin
						state_r <= scde_pkg::ST_HIGH;
						tim_r <= eff_time(sout_cfg_r[scde_pkg::HIGHT_LSB +: 4]);
						rx_r <= {rx_r[62:0], sdi_s2_r};
					end
					else
						tim_r <= tim_r - 4'h1;
				end
				scde_pkg::ST_HIGH:
				begin
					if (tim_r != 4'h1)
						tim_r <= tim_r - 4'h1;
					else if (bit_cnt_r == 7'h01)
					begin
						state_r <= scde_pkg::ST_BLOCK;
						tim_r <= eff_time(sout_cfg_r[scde_pkg::BLKT_LSB +: 4]);
					end
					else
					begin
						state_r <= scde_pkg::ST_LOW;
						tim_r <= eff_time(sout_cfg_r[scde_pkg::LOWT_LSB +: 4]);
						bit_cnt_r <= bit_cnt_r - 7'h01;
					end
				end
				scde_pkg::ST_BLOCK:
				begin
					if (tim_r == 4'h1)
						state_r <= scde_pkg::ST_IDLE;
					else
						tim_r <= tim_r - 4'h1;
				end
			endcase
		end
	end

	// Outputs: bit at index count-1 is the MSB of the datagram
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			driver_serial_clock_out <= 1'b1;
			driver_select_n_out <= 1'b1;
			driver_serial_out_out <= 1'b0;
		end
		else if (ce_in)
		begin
			driver_serial_clock_out <= state_r != scde_pkg::ST_LOW;
			driver_select_n_out <= !(state_r == scde_pkg::ST_LOW ||
				state_r == scde_pkg::ST_HIGH);
			if (state_r == scde_pkg::ST_LOW || state_r == scde_pkg::ST_HIGH)
				driver_serial_out_out <=
					tx_r.data[6'(bit_cnt_r - 7'h01)];
		end
	end

	// Reply store, status copy and events
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rp_low_r <= scde_pkg::RESET_WORD;
			rp_high_r <= scde_pkg::RESET_WORD;
			drv_status_r <= 8'h00;
			events_r <= scde_pkg::RESET_WORD;
		end
		else if (ce_in)
		begin
			if (rd_clr_events)
				events_r <= scde_pkg::RESET_WORD;
			if (xfer_end)
			begin
				{rp_high_r, rp_low_r} <= rx_r;
				drv_status_r <= rx_r[7:0];
				if (is_cover_r)
					events_r[scde_pkg::EV_DONE_BIT] <= 1'b1;
			end
			if (|(drv_status_r & step_cfg_r[scde_pkg::MASK_LSB +: 8]))
				events_r[scde_pkg::EV_MOTOR_BIT] <= 1'b1;
		end
	end
endmodule : scde_engine

/* logic/scde_pkg.sv */
// Purpose: Constants and types for the cover datagram serial engine
// Assumes: 32-bit AXI4-Lite register bus, byte address = 4 * index
// Notes: Offsets are register indices as printed
package scde_pkg;
	localparam logic [6:0] IDX_HOMING = 7'h01;
	localparam logic [6:0] IDX_SOUT_CFG = 7'h04;
	localparam logic [6:0] IDX_STEP_CFG = 7'h0a;
	localparam logic [6:0] IDX_EVENTS = 7'h0e;
	localparam logic [6:0] IDX_STATUS = 7'h0f;
	localparam logic [6:0] IDX_SW_VEL = 7'h1d;
	localparam logic [6:0] IDX_VEL_NOW = 7'h22;
	localparam logic [6:0] IDX_CUR_DATA = 7'h7b;
	localparam logic [6:0] IDX_PT_LOW = 7'h6c;
	localparam logic [6:0] IDX_PT_HIGH = 7'h6d;
	localparam logic [6:0] IDX_RP_LOW = 7'h6e;
	localparam logic [6:0] IDX_RP_HIGH = 7'h6f;
	localparam int LEN_LSB = 13;
	localparam int FMT_LSB = 0;
	localparam int LOWT_LSB = 20;
	localparam int HIGHT_LSB = 24;
	localparam int BLKT_LSB = 28;
	localparam int AUTO_COVER_BIT = 0;
	localparam int MASK_LSB = 16;
	localparam int EV_DONE_BIT = 0;
	localparam int EV_MOTOR_BIT = 30;
	localparam logic [6:0] LEN_MAX = 7'h40;
	localparam logic [6:0] LEN_WORD = 7'h20;
	localparam logic [6:0] LEN_FMT_A = 7'h0c;
	localparam logic [6:0] LEN_FMT_B = 7'h14;
	localparam logic [6:0] LEN_FMT_C = 7'h28;
	localparam logic [3:0] TIME_MIN = 4'h2;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [63:0] data;
		logic [6:0] len;
	} scde_frame_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOW,
		ST_HIGH,
		ST_BLOCK
	} scde_state_t;
endpackage : scde_pkg

/* sim/scde_engine_asserts.sv */
// Purpose: Port checks for the cover datagram engine
// Assumes: One clock domain, serial outputs registered
// Notes: Bound to every instance of the engine
module scde_engine_asserts (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic cur_req_in,
	input wire logic cur_ack_out,
	input wire logic driver_serial_clock_out,
	input wire logic driver_select_n_out,
	input wire logic driver_serial_out_out
);
	wire sck = driver_serial_clock_out;
	wire sel = driver_select_n_out;
	wire sdo = driver_serial_out_out;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	idle_high_a: assert property (sel |-> sck)
		else $error("clock low while deselected");
	block_min_a: assert property ($rose(sel) |=> sel)
		else $error("block time too short");
	low_min_a: assert property (!sel && $fell(sck) |=> !sck)
		else $error("low phase too short");
	high_min_a: assert property (!sel && $rose(sck) |=> sck)
		else $error("high phase too short");
	bit_hold_a: assert property (!sel && $rose(sck) |=> $stable(sdo))
		else $error("data moved in high phase");
	start_low_a: assert property ($fell(sel) |-> !sck)
		else $error("frame began with clock high");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	ack_cause_a: assert property (cur_ack_out |-> cur_req_in)
		else $error("ack without request");
	cover property ($fell(sel));
	cover property (s_axi_arvalid && s_axi_arready);
	cover property (cur_ack_out);
endmodule : scde_engine_asserts

bind scde_engine scde_engine_asserts u_scde_engine_asserts (.*);

/* sim/scde_driver_model.sv */
// Purpose: Behavioural serial slave in the motor driver's place
// Assumes: Idle-high clock, data taken on the rising edge
// Notes: Reply line flips when deselected, no pull resistor
module scde_driver_model (
	input wire logic sck_in,
	input wire logic sel_n_in,
	input wire logic sdi_in,
	input wire logic [63:0] reply_in,
	output logic sdo_out,
	output logic [63:0] rx_out,
	output logic [6:0] nbits_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] tx;
	initial sdo_out = 1'h0;
	always @(negedge sel_n_in)
	begin
		tx = reply_in;
		rx_out = '0;
		nbits_out = '0;
	end
	// Reply moves just after the falling clock
	always @(negedge sck_in)
	begin
		#1;
		if (!sel_n_in)
		begin
			sdo_out = tx[63];
			tx = tx << 1;
		end
	end
	always @(posedge sel_n_in) sdo_out = ~sdo_out;
	always @(posedge sck_in)
		if (!sel_n_in)
		begin
			rx_out = {rx_out[62:0], sdi_in};
			nbits_out = nbits_out + 7'h1;
		end
endmodule : scde_driver_model

/* sim/scde_engine_tb_top.sv */
// Purpose: Register-level tests of the cover datagram engine
// Assumes: Byte address is four times the register index
// Notes: Serial low and high phases set to four cycles
`define CHK(a, e) \
	begin \
		n_tests++; \
		if ((a) !== (e)) \
		begin \
			num_errors++; \
			$display("[FAIL] %0t got %h exp %h", $time, a, e); \
		end \
	end
module scde_engine_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] HI = 32'h96d2_0b4e;
	localparam logic [31:0] LO = 32'h5a3c_e1f7;
	localparam logic [63:0] RP = 64'h0123_4567_89ab_cdef;
	localparam logic [1:0] OK = scde_pkg::RESP_OKAY;
	localparam logic [3:0] FMT [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
	localparam int LEN [6] = '{12, 12, 20, 20, 40, 40};
	logic clk_in = 1'h0, rstn_in = 1'h0, ce_in = 1'h1;
	logic [8:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, cur_req_in = 1'h0;
	logic [31:0] s_axi_wdata = '0, ramp_velocity_now_in = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, cur_ack_out, driver_serial_clock_out;
	logic driver_select_n_out, driver_serial_out_out, driver_serial_in_in;
	logic [63:0] cur_data_in = '0, rp = '0, rx;
	logic [6:0] nbits;
	int num_errors = 0, n_tests = 0, frames = 0;
	scde_engine u_scde_engine (.*);
	scde_driver_model u_scde_driver_model (.sck_in(driver_serial_clock_out),
		.sel_n_in(driver_select_n_out), .sdi_in(driver_serial_out_out),
		.reply_in(rp), .sdo_out(driver_serial_in_in), .rx_out(rx),
		.nbits_out(nbits));
	initial forever #12.5 clk_in = ~clk_in;
	always @(negedge driver_select_n_out) frames++;
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic wr(input logic [6:0] i, input logic [31:0] d,
		input logic [1:0] e);
		logic ok;
		ok = 1'h0;
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		repeat (40)
			if (!ok)
			begin
				@(posedge clk_in);
				if (s_axi_awready)
					s_axi_awvalid <= 1'h0;
				if (s_axi_wready)
					s_axi_wvalid <= 1'h0;
				if (s_axi_bvalid)
				begin
					ok = 1'h1;
					`CHK(s_axi_bresp, e)
				end
			end
		`CHK(ok, 1'h1)
	endtask : wr
	task automatic rdr(input logic [6:0] i, input logic [1:0] e);
		logic ok;
		ok = 1'h0;
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'h1;
		repeat (40)
			if (!ok)
			begin
				@(posedge clk_in);
				if (s_axi_arready)
					s_axi_arvalid <= 1'h0;
				if (s_axi_rvalid)
				begin
					ok = 1'h1;
					rd = s_axi_rdata;
					`CHK(s_axi_rresp, e)
				end
			end
		`CHK(ok, 1'h1)
	endtask : rdr
	task automatic frame(input int t);
		repeat (3000)
			if (frames < t || !driver_select_n_out)
				@(posedge clk_in);
		repeat (4) @(posedge clk_in);
		`CHK(frames, t)
	endtask : frame
	task automatic xfer(input logic [6:0] l, input logic [3:0] f,
		input int n, input logic [7:0] m);
		logic [63:0] k;
		int t;
		k = (64'h1 << n) - 64'h1;
		t = frames + 1;
		rp = RP << (64 - n);
		wr(scde_pkg::IDX_SOUT_CFG, {12'h044, l, 9'h0, f}, OK);
		wr(scde_pkg::IDX_STEP_CFG, {8'h0, m, 16'h0}, OK);
		rdr(scde_pkg::IDX_EVENTS, OK);
		wr(scde_pkg::IDX_PT_HIGH, HI, OK);
		wr(scde_pkg::IDX_PT_LOW, LO, OK);
		frame(t);
		`CHK(nbits, n[6:0])
		`CHK(rx, {HI, LO} & k)
		rdr(scde_pkg::IDX_RP_LOW, OK);
		`CHK(rd & k[31:0], RP[31:0] & k[31:0])
		rdr(scde_pkg::IDX_RP_HIGH, OK);
		`CHK(rd & k[63:32], RP[63:32] & k[63:32])
		rdr(scde_pkg::IDX_STATUS, OK);
		`CHK(rd[31:24], RP[7:0])
		rdr(scde_pkg::IDX_EVENTS, OK);
		`CHK(rd, {1'h0, |(m & RP[7:0]), 29'h0, 1'h1})
		rdr(scde_pkg::IDX_EVENTS, OK);
		`CHK(rd[0], 1'h0)
	endtask : xfer
	initial
	begin
		#1ms;
		num_errors++;
		final_report;
	end
	initial
	begin
		int k;
		repeat (16) @(posedge clk_in);
		rstn_in <= 1'h1;
		@(posedge clk_in);
		rdr(scde_pkg::IDX_PT_HIGH, OK);
		`CHK(rd, scde_pkg::RESET_WORD)
		foreach (FMT[i])
			xfer(7'h0, FMT[i], LEN[i], 8'h01);
		xfer(7'h46, 4'ha, 64, 8'h10);
		xfer(7'h21, 4'hc, 33, 8'h10);
		xfer(7'h10, 4'ha, 16, 8'h00);
		ramp_velocity_now_in <= 32'h32;
		wr(scde_pkg::IDX_SW_VEL, 32'h64, OK);
		rdr(scde_pkg::IDX_SW_VEL, OK);
		`CHK(rd, 32'h64)
		wr(scde_pkg::IDX_HOMING, 32'h1, OK);
		repeat (50) @(posedge clk_in);
		k = frames;
		ramp_velocity_now_in <= 32'hffff_ff6a;
		frame(k + 1);
		`CHK(rx, {48'h0, HI[15:0]})
		ramp_velocity_now_in <= 32'h14;
		frame(k + 2);
		`CHK(rx, {48'h0, LO[15:0]})
		repeat (200) @(posedge clk_in);
		`CHK(frames, k + 2)
		wr(scde_pkg::IDX_SOUT_CFG, 32'h0444_200a, OK);
		ramp_velocity_now_in <= 32'h96;
		repeat (200) @(posedge clk_in);
		`CHK(frames, k + 2)
		wr(scde_pkg::IDX_HOMING, 32'h0, OK);
		wr(scde_pkg::IDX_SOUT_CFG, 32'h0440_0000, OK);
		wr(scde_pkg::IDX_PT_LOW, LO, OK);
		repeat (300) @(posedge clk_in);
		`CHK(frames, k + 2)
		wr(scde_pkg::IDX_SOUT_CFG, 32'h0440_0008, OK);
		wr(scde_pkg::IDX_PT_LOW, LO, OK);
		wr(scde_pkg::IDX_PT_LOW, LO, OK);
		frame(k + 4);
		`CHK(rx, {52'h0, LO[11:0]})
		rp <= {12'h5e1, 52'h0};
		cur_data_in <= 64'h0abc;
		cur_req_in <= 1'h1;
		@(posedge clk_in);
		repeat (100)
			if (cur_req_in)
			begin
				if (cur_ack_out)
					cur_req_in <= 1'h0;
				@(posedge clk_in);
			end
		`CHK(cur_req_in, 1'h0)
		frame(k + 5);
		`CHK(rx, 64'habc)
		rdr(scde_pkg::IDX_RP_LOW, OK);
		`CHK(rd[11:0], 12'h5e1)
		rdr(7'h30, scde_pkg::RESP_SLVERR);
		`CHK(rd, 32'h0)
		wr(scde_pkg::IDX_RP_LOW, 32'h1, scde_pkg::RESP_SLVERR);
		final_report;
	end
endmodule : scde_engine_tb_top
